/* verilog/mcdr_top.sv */
`timescale 1ns/10ps
module mcdr_top
   import mcdr_pkg::*;
(
   input  wire logic                   clock_in,
   input  wire logic                   arst_n_in,
   input  wire logic                   wr_en_in,
   input  wire logic [7:0]             wr_addr_in,
   input  wire logic [7:0]             wr_data_in,
   input  wire logic [7:0]             rd_addr_in,
   input  wire logic                   sample_tick_in,
   input  wire logic                   mode_change_in,
   input  wire mcdr_pkg::mcdr_axes_s   accel_in,
   input  wire logic [DATA_W-1:0]      magnitude_in,
   input  wire logic [2:0]             outside_axis_in,
   input  wire logic [2:0]             inside_axis_in,
   input  wire logic [2:0]             outside_axis_en_in,
   input  wire logic [2:0]             inside_axis_en_in,
   output logic [7:0]                  rd_data_out,
   output logic                        outside_flag_out,
   output logic                        inside_flag_out,
   output mcdr_pkg::mcdr_axes_s        baseline_out
);
   import mcdr_pkg::*;

   mcdr_ctl_s        ctl;
   logic [CNT_W-1:0] out_limit;
   logic [CNT_W-1:0] in_limit;
   logic             enable_q;
   logic             first_pending;
   logic             refresh_done;
   logic [2:0]       out_en_eff;
   logic [2:0]       in_en_eff;
   logic             out_cond;
   logic             in_cond;
   logic             out_flag;
   logic             in_flag;
   logic             out_flag_q;
   mcdr_axes_s       next_base;
   mcdr_axes_s       sample;
   mcdr_ref_e        ref_state;
   logic             do_load;

   // control register; refresh bit set by host, cleared by hardware
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ctl <= mcdr_ctl_s'(CTL_RESET);
      end else if (wr_en_in && wr_addr_in == CTL_OFFSET) begin
         ctl <= mcdr_ctl_s'(wr_data_in);
         // a fresh write of one wins over the completing clear
         if (!wr_data_in[CTL_REFRESH_BIT] && !refresh_done) begin
            ctl.refresh <= ctl.refresh & ~refresh_done;
         end
      end else if (refresh_done) begin
         ctl.refresh <= 1'b0;
      end
   end

   // debounce limits
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         out_limit <= LIMIT_RESET;
         in_limit  <= LIMIT_RESET;
      end else if (wr_en_in && wr_addr_in == OUT_LIMIT_OFFSET) begin
         out_limit <= wr_data_in;
      end else if (wr_en_in && wr_addr_in == IN_LIMIT_OFFSET) begin
         in_limit <= wr_data_in;
      end
   end

   // readback from a register; unmapped offsets read zero
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_out <= 8'h00;
      end else begin
         case (rd_addr_in)
            CTL_OFFSET:       rd_data_out <= ctl;
            OUT_LIMIT_OFFSET: rd_data_out <= out_limit;
            IN_LIMIT_OFFSET:  rd_data_out <= in_limit;
            default:          rd_data_out <= 8'h00;
         endcase
      end
   end

   // magnitude mode uses x channel only; others dropped
   always_comb begin
      if (ctl.magnitude_sel) begin
         out_en_eff = {outside_axis_en_in[2], 2'b00};
         in_en_eff  = {inside_axis_en_in[2], 2'b00};
      end else begin
         out_en_eff = outside_axis_en_in;
         in_en_eff  = inside_axis_en_in;
      end
   end

   // outside: any enabled axis out; inside: AND or OR
   always_comb begin
      out_cond = |(outside_axis_in & out_en_eff);
      if (ctl.in_combine) begin
         in_cond = |(inside_axis_in & in_en_eff);
      end else begin
         in_cond = (in_en_eff != 3'b000)
                   && &(inside_axis_in | ~in_en_eff);
      end
   end

   // comparator input sample; magnitude feeds x lane
   always_comb begin
      sample = accel_in;
      if (ctl.magnitude_sel) begin
         sample.x = magnitude_in;
      end
   end

   mcdr_debounce #(
      .CNT_W (CNT_W)
   ) u_outside (
      .clock_in      (clock_in),
      .arst_n_in     (arst_n_in),
      .tick_in       (sample_tick_in & ctl.enable),
      .restart_in    (mode_change_in | ~ctl.enable),
      .cond_in       (out_cond),
      .clear_mode_in (ctl.out_count_mode),
      .limit_in      (out_limit),
      .flag_out      (out_flag)
   );

   mcdr_debounce #(
      .CNT_W (CNT_W)
   ) u_inside (
      .clock_in      (clock_in),
      .arst_n_in     (arst_n_in),
      .tick_in       (sample_tick_in & ctl.enable),
      .restart_in    (mode_change_in | ~ctl.enable),
      .cond_in       (in_cond),
      .clear_mode_in (ctl.in_count_mode),
      .limit_in      (in_limit),
      .flag_out      (in_flag)
   );

   // flags registered so outputs come from flops
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         outside_flag_out <= 1'b0;
         inside_flag_out  <= 1'b0;
         out_flag_q       <= 1'b0;
      end else begin
         outside_flag_out <= out_flag;
         inside_flag_out  <= in_flag;
         out_flag_q       <= out_flag;
      end
   end

   // enable edge arms the first-sample capture
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         enable_q      <= 1'b0;
         first_pending <= 1'b0;
      end else begin
         enable_q <= ctl.enable;
         if (ctl.enable && !enable_q) begin
            first_pending <= 1'b1;
         end else if (sample_tick_in || !ctl.enable) begin
            first_pending <= 1'b0;
         end
      end
   end

   // refresh waits for next sample; reload then done
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ref_state <= MCDR_IDLE;
      end else begin
         case (ref_state)
            MCDR_IDLE:    if (ctl.refresh) ref_state <= MCDR_PENDING;
            MCDR_PENDING: if (sample_tick_in) ref_state <= MCDR_LOAD;
            MCDR_LOAD:    ref_state <= MCDR_IDLE;
            default:      ref_state <= MCDR_IDLE;
         endcase
      end
   end
   assign refresh_done = (ref_state == MCDR_LOAD);
   assign do_load      = refresh_done;

   // baseline update by policy
   always_comb begin
      next_base = baseline_out;
      if (ctl.policy == POLICY_ABSOLUTE) begin
         next_base = '0;
      end else if (do_load) begin
         next_base = sample;
      end else if (ctl.enable && ctl.policy == POLICY_TRACK
                   && out_flag && !out_flag_q) begin
         // the flag rises the cycle after its tick, so no tick gate here
         next_base = sample;
      end else if (sample_tick_in && ctl.enable) begin
         if (first_pending) begin
            next_base = sample;
         end else if (ctl.policy == POLICY_SLOPE) begin
            next_base = sample;
         end
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         baseline_out <= '0;
      end else begin
         baseline_out <= next_base;
      end
   end

   chk_absolute_zero: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      ctl.policy == POLICY_ABSOLUTE |=> baseline_out == '0)
      else $error("absolute policy baseline not zero");
   chk_refresh_load: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      ref_state == MCDR_PENDING && sample_tick_in
      && ctl.policy != POLICY_ABSOLUTE |=> ##1 baseline_out == $past(sample))
      else $error("refresh did not load baseline");
   chk_hold_steady: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      ctl.policy == POLICY_HOLD && !first_pending && !do_load
      && $past(ctl.policy) == POLICY_HOLD |=> $stable(baseline_out))
      else $error("hold policy baseline moved");
   chk_refresh_clears: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      refresh_done && !wr_en_in |=> !ctl.refresh)
      else $error("refresh bit not self cleared");
   chk_mode_restart: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      mode_change_in |=> !out_flag && !in_flag ##1 !outside_flag_out)
      else $error("mode change did not reset debounce");
   chk_refresh_prompt: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      ref_state == MCDR_PENDING && sample_tick_in |=> refresh_done)
      else $error("refresh not done within one sample period");

   // window combine and disable checks; y and z must not matter in magnitude mode
   chk_magnitude_x_only: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      ctl.magnitude_sel && !ctl.in_combine && inside_axis_in[2]
      && inside_axis_en_in[2] |-> in_cond)
      else $error("magnitude mode did not ignore y and z");
   chk_and_combine: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      !ctl.in_combine && !ctl.magnitude_sel
      && (inside_axis_in & inside_axis_en_in) != inside_axis_en_in
      |-> !in_cond)
      else $error("and combine passed a missing axis");
   chk_or_combine: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      ctl.in_combine && !ctl.magnitude_sel
      && (inside_axis_in & inside_axis_en_in) != 3'b000 |-> in_cond)
      else $error("or combine missed an axis");
   chk_disabled_quiet: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      !ctl.enable |=> !out_flag && !in_flag)
      else $error("debounce flag set while detector disabled");

   cov_refresh: cover property (@(posedge clock_in)
      disable iff (!arst_n_in) refresh_done);
   cov_magnitude: cover property (@(posedge clock_in)
      disable iff (!arst_n_in) ctl.magnitude_sel && in_cond);
   cov_track_reload: cover property (@(posedge clock_in)
      disable iff (!arst_n_in)
      ctl.policy == POLICY_TRACK && out_flag && !out_flag_q);
endmodule

/* verilog/mcdr_pkg.sv */
package mcdr_pkg;

   // change_detect_control field positions
   localparam int CTL_REFRESH_BIT  = 0;
   localparam int CTL_MODE_BIT     = 1;
   localparam int CTL_COMBINE_BIT  = 2;
   localparam int CTL_IN_CM_BIT    = 3;
   localparam int CTL_OUT_CM_BIT   = 4;
   localparam int CTL_POLICY_LO    = 5;
   localparam int CTL_ENABLE_BIT   = 7;

   // register offsets (byte addresses of the device map)
   localparam logic [7:0] CTL_OFFSET      = 8'h30;
   localparam logic [7:0] OUT_LIMIT_OFFSET = 8'h31;
   localparam logic [7:0] IN_LIMIT_OFFSET  = 8'h32;

   // reset values
   localparam logic [7:0] CTL_RESET       = 8'h00;
   localparam logic [7:0] LIMIT_RESET     = 8'h00;

   // reference policies
   localparam logic [1:0] POLICY_TRACK    = 2'h0;
   localparam logic [1:0] POLICY_HOLD     = 2'h1;
   localparam logic [1:0] POLICY_SLOPE    = 2'h2;
   localparam logic [1:0] POLICY_ABSOLUTE = 2'h3;

   localparam int DATA_W = 12;
   localparam int CNT_W  = 8;

   // decoded control bits
   typedef struct packed {
      logic       enable;
      logic [1:0] policy;
      logic       out_count_mode;
      logic       in_count_mode;
      logic       in_combine;
      logic       magnitude_sel;
      logic       refresh;
   } mcdr_ctl_s;

   // one sample of per-axis data
   typedef struct packed {
      logic [DATA_W-1:0] x;
      logic [DATA_W-1:0] y;
      logic [DATA_W-1:0] z;
   } mcdr_axes_s;

   typedef enum logic [1:0] {
      MCDR_IDLE,
      MCDR_PENDING,
      MCDR_LOAD
   } mcdr_ref_e;

endpackage

/* verilog/mcdr_debounce.sv */
`timescale 1ns/10ps
// one debounce counter with decrementing or clearing mode
module mcdr_debounce #(
   parameter int CNT_W = 8
) (
   input  wire logic             clock_in,
   input  wire logic             arst_n_in,
   input  wire logic             tick_in,
   input  wire logic             restart_in,
   input  wire logic             cond_in,
   input  wire logic             clear_mode_in,
   input  wire logic [CNT_W-1:0] limit_in,
   output logic                  flag_out
);
   logic [CNT_W-1:0] count;
   logic             flag;

   // counter per sample period; restart on mode change
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count <= '0;
      end else if (restart_in) begin
         count <= '0;
      end else if (tick_in) begin
         if (cond_in) begin
            if (count < limit_in) begin
               count <= count + 1'b1;
            end
         end else if (clear_mode_in) begin
            count <= '0;
         end else if (count != '0) begin
            count <= count - 1'b1;
         end
      end
   end

   // flag set at limit; in decrementing mode held until count drains
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag <= 1'b0;
      end else if (restart_in) begin
         flag <= 1'b0;
      end else if (tick_in) begin
         if (cond_in && (count + 1'b1 >= {1'b0, limit_in})) begin
            flag <= 1'b1;
         end else if (!cond_in && (clear_mode_in || count == '0)) begin
            flag <= 1'b0;
         end
      end
   end

   assign flag_out = flag;

   chk_clear_mode_zero: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      (tick_in && !restart_in && clear_mode_in && !cond_in) |=> count == '0)
      else $error("clearing mode did not zero counter");
   chk_dec_step: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      (tick_in && !restart_in && !clear_mode_in && !cond_in
       && count != '0) |=> count == $past(count) - 1'b1)
      else $error("decrement step wrong");
   chk_limit_cap: assert property (@(posedge clock_in)
      disable iff (!arst_n_in)
      !restart_in && $past(count) <= $past(limit_in)
      && limit_in == $past(limit_in) |-> count <= limit_in)
      else $error("counter passed limit");
   cov_flag_set: cover property (@(posedge clock_in)
      disable iff (!arst_n_in) $rose(flag));
   cov_flag_drop: cover property (@(posedge clock_in)
      disable iff (!arst_n_in) $fell(flag));
endmodule

/* verif/mcdr_host.sv */
`timescale 1ns/10ps
// host side of the register port: one-cycle write strobe, registered reads
module mcdr_host (
   input  wire logic       clock_in,
   input  wire logic [7:0] rd_data_in,
   output logic            wr_en_out,
   output logic [7:0]      wr_addr_out,
   output logic [7:0]      wr_data_out,
   output logic [7:0]      rd_addr_out
);
   // idle values at time zero
   initial begin
      wr_en_out   = 1'b0;
      wr_addr_out = 8'h00;
      wr_data_out = 8'h00;
      rd_addr_out = 8'h00;
   end

   // strobe for one edge, then scramble address and data so stale
   // values can never pass for a write
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      wr_en_out   <= 1'b1;
      wr_addr_out <= a;
      wr_data_out <= d;
      @(posedge clock_in);
      wr_en_out   <= 1'b0;
      wr_addr_out <= ~a;
      wr_data_out <= ~d;
   endtask

   // read data is registered one cycle after the address
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      rd_addr_out <= a;
      @(posedge clock_in);
      @(posedge clock_in);
      #1;
      d = rd_data_in;
   endtask
endmodule

/* verif/mcdr_top_tb.sv */
`timescale 1ns/10ps
module mcdr_top_tb;
   import mcdr_pkg::*;
   logic        clock_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        wr_en, tick, mchg;
   logic [7:0]  wr_addr, wr_data, rd_addr, rd_data, rd;
   logic [2:0]  oa = 3'h0;
   logic [2:0]  ia = 3'h0;
   logic [2:0]  oae = 3'h7;
   logic [2:0]  iae = 3'h7;
   logic        o_flag, i_flag;
   mcdr_axes_s  accel, base;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cycles = 0;

   initial begin
      tick = 1'b0;
      mchg = 1'b0;
      accel = '0;
   end
   // 20 MHz
   always #25 clock_in = ~clock_in;

   mcdr_host mcdr_host_inst (.clock_in(clock_in), .rd_data_in(rd_data),
      .wr_en_out(wr_en), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
      .rd_addr_out(rd_addr));

   mcdr_top mcdr_top_inst (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .wr_en_in(wr_en), .wr_addr_in(wr_addr), .wr_data_in(wr_data),
      .rd_addr_in(rd_addr), .sample_tick_in(tick), .mode_change_in(mchg),
      .accel_in(accel), .magnitude_in(12'h0a5), .outside_axis_in(oa),
      .inside_axis_in(ia), .outside_axis_en_in(oae),
      .inside_axis_en_in(iae), .rd_data_out(rd_data),
      .outside_flag_out(o_flag), .inside_flag_out(i_flag),
      .baseline_out(base));

   task automatic check(input string n, input logic [35:0] e,
                        input logic [35:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   // n sample ticks with the given window results; flags land 2 edges on
   task automatic ticks(input int n, input logic [2:0] o,
                        input logic [2:0] i);
      repeat (n) begin
         @(posedge clock_in);
         tick <= 1'b1;
         oa <= o;
         ia <= i;
         @(posedge clock_in);
         tick <= 1'b0;
      end
      repeat (2) @(posedge clock_in);
      #1;
   endtask

   // power mode change pulse restarts both counters
   task automatic restart();
      @(posedge clock_in);
      mchg <= 1'b1;
      @(posedge clock_in);
      mchg <= 1'b0;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard, far beyond the 165 or so cycles the tests need
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(posedge clock_in);
      arst_n_in <= 1'b1;
      mcdr_host_inst.read_reg(CTL_OFFSET, rd);
      check("ctl reset", CTL_RESET, rd);
      mcdr_host_inst.read_reg(OUT_LIMIT_OFFSET, rd);
      check("out limit reset", LIMIT_RESET, rd);
      mcdr_host_inst.read_reg(8'h3f, rd);
      check("unmapped read", 8'h00, rd);
      // outside, decrement mode, limit 3
      mcdr_host_inst.write_reg(OUT_LIMIT_OFFSET, 8'h03);
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'h80);
      restart();
      ticks(2, 3'h4, 3'h0);
      check("out flag early", 1'b0, o_flag);
      ticks(1, 3'h4, 3'h0);
      check("out flag set", 1'b1, o_flag);
      ticks(3, 3'h0, 3'h0);
      check("out flag held", 1'b1, o_flag);
      ticks(1, 3'h0, 3'h0);
      check("out flag drop", 1'b0, o_flag);
      // outside, clear mode
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'h90);
      restart();
      ticks(2, 3'h1, 3'h0);
      ticks(1, 3'h0, 3'h0);
      ticks(2, 3'h1, 3'h0);
      check("out clear early", 1'b0, o_flag);
      ticks(1, 3'h1, 3'h0);
      check("out clear set", 1'b1, o_flag);
      ticks(1, 3'h0, 3'h0);
      check("out clear drop", 1'b0, o_flag);
      // inside combine, clear mode, limit 0
      mcdr_host_inst.write_reg(IN_LIMIT_OFFSET, 8'h00);
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'h88);
      ticks(1, 3'h0, 3'h3);
      check("in and", 1'b0, i_flag);
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'h8c);
      ticks(1, 3'h0, 3'h3);
      check("in or", 1'b1, i_flag);
      ticks(1, 3'h0, 3'h0);
      check("in clear drop", 1'b0, i_flag);
      // inside, decrement mode, limit 2
      mcdr_host_inst.write_reg(IN_LIMIT_OFFSET, 8'h02);
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'h80);
      restart();
      ticks(2, 3'h0, 3'h7);
      check("in flag set", 1'b1, i_flag);
      ticks(2, 3'h0, 3'h0);
      check("in flag held", 1'b1, i_flag);
      ticks(1, 3'h0, 3'h0);
      check("in flag drop", 1'b0, i_flag);
      // refresh under absolute policy leaves baselines at zero
      @(posedge clock_in);
      accel <= {12'h123, 12'h456, 12'h789};
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'he1);
      repeat (2) @(posedge clock_in);
      ticks(1, 3'h0, 3'h0);
      check("absolute base", 36'h0, base);
      // refresh under hold policy loads within one sample period
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'ha1);
      repeat (2) @(posedge clock_in);
      ticks(1, 3'h0, 3'h0);
      check("refresh base", 36'h123_4567_89, base);
      mcdr_host_inst.read_reg(CTL_OFFSET, rd);
      check("refresh clears", 8'ha0, rd);
      @(posedge clock_in);
      accel <= {12'h0aa, 12'h0bb, 12'h0cc};
      ticks(2, 3'h0, 3'h0);
      check("hold base", 36'h123_4567_89, base);
      // policy 00: baselines follow data when the outside flag rises
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'h80);
      restart();
      ticks(3, 3'h4, 3'h0);
      check("track flag", 1'b1, o_flag);
      check("track base", 36'h0_aa0b_b0cc, base);
      // magnitude on the x lane; magnitude_in stands for a host that
      // has also set magnitude_calc_enable
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'ha3);
      ticks(2, 3'h0, 3'h4);
      check("magnitude in flag", 1'b1, i_flag);
      check("magnitude base", 36'h0_a50b_b0cc, base);
      // a power mode change restarts both debounce counters
      restart();
      repeat (2) @(posedge clock_in);
      #1;
      check("restart out flag", 1'b0, o_flag);
      check("restart in flag", 1'b0, i_flag);
      // slope policy: baselines take each new sample
      @(posedge clock_in);
      accel <= {12'h111, 12'h222, 12'h333};
      mcdr_host_inst.write_reg(CTL_OFFSET, 8'hc0);
      ticks(1, 3'h0, 3'h0);
      check("slope base", 36'h1_1122_2333, base);
      summarize();
   end
endmodule
